// ### wdtt_pkg.sv
// Purpose: Shared constants for the watchdog time-out timer.
// Assumes: System clock of 100 MHz and a slow oscillator near 10 kHz.
// Notes:   The slow oscillator only paces the count; it is never a clock.
package wdtt_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000; // System clock rate.
  localparam int unsigned SLOW_OSC_HZ    = 10_000;      // Nominal slow oscillator rate.
  localparam int unsigned INTERVAL_COUNT = 64;          // Prescaled periods per time-out.
  localparam int unsigned CNT_W          = 6;           // Width of the interval counter.
  localparam int unsigned PS_W           = 3;           // Width of the prescale select.
  localparam int unsigned DIV_W          = 8;           // Divider chain, up to 1/256.
  localparam int unsigned MODE_W         = 4;           // Width of the mode field.
  localparam logic [3:0]  MODE_TIMER     = 4'hF;        // Erased field: general timer.
  localparam logic [5:0]  CNT_LAST       = 6'(INTERVAL_COUNT - 1); // Final count value.
  localparam int unsigned RST_DELAY_DEF  = 4;           // Prescaled ticks before reset.
endpackage

// ### wdtt_tick_if.sv
`timescale 1ns/100ps
// Purpose: Carries the prescale select and the prescaled tick between modules.
// Assumes: Both ends run on clk_i.
// Notes:   The tick is a one-cycle pulse.
interface wdtt_tick_if;
  logic [2:0] sel;  // Prescale select from the core.
  logic       tick; // One pulse per prescaled slow period.
  modport pre  (input sel, output tick);
  modport core (output sel, input tick);
endinterface

// ### wdtt_prescale.sv
`timescale 1ns/100ps
// Purpose: Synchronises the slow oscillator and divides it by the selected scale.
// Assumes: The slow oscillator is far slower than clk_i.
// Notes:   The slow oscillator is sampled like a pin, so jitter of one cycle is normal.
module wdtt_prescale
  import wdtt_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  input  wire logic    slow_internal_osc_i,
  wdtt_tick_if.pre     tk
);
  logic             sync1;     // First synchroniser stage, read only by sync2.
  logic             sync2;     // Second synchroniser stage.
  logic             sync3;     // Delayed copy for rising edge detection.
  logic             slow_edge; // One cycle per slow oscillator rising edge.
  logic [DIV_W-1:0] div_cnt;   // Free running divider chain.
  logic [2:0]       fill;      // Ones shift in after reset to arm the edge detector.

  // Decodes a prescale code into the mask of divider bits that must be all ones.
  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] s);
    logic [3:0] sh;
    sh = (s == 3'h0) ? 4'h0 : 4'({1'b0, s} + 4'h1);
    return 8'((9'h001 << sh) - 9'h001);
  endfunction

  // Two flops before any logic reads the oscillator level.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= slow_internal_osc_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edge detection waits until both compared stages hold real pin samples, so a high level
  // found at reset release is never mistaken for a fresh rising edge of the oscillator.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill <= 3'h0;
    end else begin
      fill <= {fill[1:0], 1'b1};
    end
  end

  assign slow_edge = fill[2] & sync2 & ~sync3;

  // The chain advances only on slow edges, never on the system clock alone.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 8'h00;
    end else if (slow_edge) begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // A tick leaves when the masked low bits roll over; code 0 ticks every edge.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tk.tick <= 1'b0;
    end else begin
      tk.tick <= slow_edge && ((div_cnt & div_mask(tk.sel)) == div_mask(tk.sel));
    end
  end

  tick_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tk.tick |-> $past(slow_edge))
    else $error("Tick without a slow oscillator edge.");

  div_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tk.tick |-> (($past(div_cnt) & div_mask($past(tk.sel))) == div_mask($past(tk.sel))))
    else $error("Tick does not match selected divide fraction.");
endmodule

// ### wdtt_top.sv
`timescale 1ns/100ps
// Purpose: Watchdog that counts 64 prescaled slow periods per time-out.
// Assumes: Mode field, prescale select, enable and clear come from clk_i logic.
// Notes:   The device reset output holds until rst_i is applied again.
module wdtt_top
  import wdtt_pkg::*;
#(
  parameter int unsigned RST_DELAY_TICKS = RST_DELAY_DEF // Prescaled ticks before reset.
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_internal_osc_i,   // Slow oscillator level.
  input  wire logic [3:0]  watchdog_mode_cfg_i,   // Field of config_byte_four.
  input  wire logic [2:0]  watchdog_prescale_sel_i,
  input  wire logic        int_enable_i,          // Interrupt enable.
  input  wire logic        clear_i,               // Software service pulse.
  output logic             wake_o,                // Wake-up pulse.
  output logic             timeout_irq_o,         // Interrupt pulse.
  output logic             timeout_flag_o,        // Sticky time-out flag.
  output logic             dev_reset_o            // Whole device reset request.
);
  // The delay counter is eight bits wide, so longer delays cannot be served.
  if (RST_DELAY_TICKS < 1 || RST_DELAY_TICKS > 256) begin : g_bad_delay
    $error("RST_DELAY_TICKS must lie in 1 to 256.");
  end

  localparam logic [7:0] DELAY_LAST = 8'(RST_DELAY_TICKS - 1); // Final delay tick.

  // The counter wraps by itself at the end of an interval, so its width must match the count.
  if (INTERVAL_COUNT != (1 << CNT_W)) begin : g_bad_interval
    $error("INTERVAL_COUNT must equal two to the power of CNT_W.");
  end

  wdtt_tick_if       tk ();        // Link to the prescaler.
  logic              cfg_done;     // Mode field has been captured.
  logic              reset_mode;   // High when acting as time-out reset timer.
  logic [CNT_W-1:0]  cnt;          // Interval counter.
  logic              expire;       // Interval fulfilled this cycle.
  logic              pending;      // Reset delay is running.
  logic [7:0]        delay_cnt;    // Ticks spent in the reset delay.

  assign tk.sel = watchdog_prescale_sel_i;

  wdtt_prescale u_pre (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .slow_internal_osc_i (slow_internal_osc_i),
    .tk                  (tk)
  );

  // The mode is caught once after reset, as a nonvolatile byte would be loaded.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_done   <= 1'b0;
      reset_mode <= 1'b0;
    end else if (!cfg_done) begin
      cfg_done   <= 1'b1;
      reset_mode <= (watchdog_mode_cfg_i != MODE_TIMER);
    end
  end

  // Expiry is seen even if a clear lands on the same cycle, so no event is lost.
  assign expire = tk.tick && (cnt == CNT_LAST);

  // The counter has no low power gate at all, so it keeps running in any mode.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (clear_i) begin
      cnt <= '0;
    end else if (tk.tick) begin
      cnt <= cnt + 6'h01;
    end
  end

  // Wake-up pulses follow every expiry by one cycle; interrupt pulses only while int_enable_i is set.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_o        <= 1'b0;
      timeout_irq_o <= 1'b0;
    end else begin
      wake_o        <= expire;
      timeout_irq_o <= expire && int_enable_i;
    end
  end

  // Sticky flag: a set wins over a clear in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_flag_o <= 1'b0;
    end else begin
      timeout_flag_o <= expire | (timeout_flag_o & ~clear_i);
    end
  end

  // Reset delay: started by an expiry in reset mode, cancelled by service.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending   <= 1'b0;
      delay_cnt <= 8'h00;
    end else if (expire && reset_mode && !pending) begin
      pending   <= 1'b1;
      delay_cnt <= 8'h00;
    end else if (clear_i) begin
      pending   <= 1'b0;
      delay_cnt <= 8'h00;
    end else if (pending && tk.tick) begin
      delay_cnt <= delay_cnt + 8'h01;
    end
  end

  // Once asserted the request stays up; only the device reset itself removes it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_reset_o <= 1'b0;
    end else if (pending && tk.tick && !clear_i && (delay_cnt == DELAY_LAST)) begin
      dev_reset_o <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_expire;
    tk.tick && (cnt == CNT_LAST);
  endsequence

  // A service that is not overtaken by the start of a reset delay in the same cycle.
  sequence s_served;
    clear_i && !(expire && reset_mode && !pending);
  endsequence

  // An expiry in reset mode that opens the reset delay.
  sequence s_delay_start;
    expire && reset_mode && !pending;
  endsequence

  // The mode is frozen once captured, as a loaded configuration byte would be.
  mode_latch_a: assert property (
    $past(cfg_done) |-> $stable(reset_mode))
    else $error("Mode changed after capture.");

  // The general timer never starts a reset delay.
  timer_quiet_a: assert property (
    !reset_mode |-> !pending)
    else $error("Reset delay running in timer mode.");

  // A wake-up needs a full interval of 64 ticks behind it.
  interval_a: assert property (
    wake_o |-> ($past(cnt) == 6'h3F) && $past(tk.tick))
    else $error("Wake-up without a full 64-count interval.");

  // Without a tick or a service the count stands still.
  cnt_hold_a: assert property (
    (!tk.tick && !clear_i) |=> $stable(cnt))
    else $error("Counter moved without a tick.");

  // Every expiry gives a wake-up on the next cycle.
  wake_pulse_a: assert property (
    s_expire |=> wake_o)
    else $error("Expiry gave no wake-up.");

  // A wake-up is a single-cycle pulse.
  wake_single_a: assert property (
    wake_o |=> !wake_o)
    else $error("Wake-up pulse stretched.");

  // The interrupt follows the enable as it stood at expiry.
  irq_gate_a: assert property (
    s_expire |=> (timeout_irq_o == $past(int_enable_i)))
    else $error("Interrupt does not follow its enable.");

  // No interrupt leaves without its wake-up.
  irq_with_wake_a: assert property (
    timeout_irq_o |-> wake_o)
    else $error("Interrupt without an expiry.");

  // The event flag stays up until software clears it.
  flag_hold_a: assert property (
    s_expire |=> timeout_flag_o ##1 (timeout_flag_o || $past(clear_i)))
    else $error("Time-out flag lost.");

  // The delay starts from zero on the expiry that opens it.
  delay_start_a: assert property (
    s_delay_start |=> pending && (delay_cnt == 8'h00))
    else $error("Reset delay did not start.");

  // Each tick of an unserved delay advances it by one.
  delay_step_a: assert property (
    (pending && tk.tick && !clear_i) |=> (delay_cnt == $past(delay_cnt) + 8'h01))
    else $error("Reset delay did not advance.");

  // The last tick of the delay raises the device reset.
  delay_end_a: assert property (
    (pending && tk.tick && !clear_i && (delay_cnt == DELAY_LAST)) |=> dev_reset_o)
    else $error("Device reset missing after the delay.");

  // The device reset only rises from a running delay in reset mode.
  reset_cause_a: assert property (
    $rose(dev_reset_o) |-> reset_mode && $past(pending) && $past(tk.tick))
    else $error("Device reset without expired delay in reset mode.");

  // The device reset never rises before the delay has run out.
  reset_late_a: assert property (
    $rose(dev_reset_o) |-> ($past(delay_cnt) == DELAY_LAST))
    else $error("Device reset before the delay ran out.");

  // Once raised, the device reset holds until rst_i.
  reset_hold_a: assert property (
    dev_reset_o |=> dev_reset_o)
    else $error("Device reset dropped.");

  // The count advances on every tick without a service, as nothing gates it in any power mode.
  keep_count_a: assert property (
    (tk.tick && !clear_i) |=> (cnt == $past(cnt) + 6'h01))
    else $error("Counter did not advance on a tick.");

  // A service restarts the count and cancels a running delay.
  serve_cancel_a: assert property (
    s_served |=> !pending && (cnt == 6'h00))
    else $error("Service did not restart the count.");

  // A service always restarts the interval, even on an expiry cycle.
  clear_count_a: assert property (
    clear_i |=> (cnt == 6'h00))
    else $error("Service did not clear the counter.");
endmodule

// ### watchdog_timeout_timer_tb.sv
`timescale 1ns/100ps
// Purpose: Self-checking bench for the watchdog time-out timer.
// Assumes: The slow oscillator is sped up to 8 clk per period to keep runs short.
// Notes:   Periods are measured between two wakes, as the first may be short.
module watchdog_timeout_timer_tb;
  import wdtt_pkg::*;
  localparam int unsigned DLY  = 2; // Short reset delay keeps the run brief.
  localparam int unsigned HALF = 4; // Clock cycles per slow oscillator phase.
  logic       clk_i;
  logic       rst_i;
  logic       slow_internal_osc_i = 1'b0;
  logic [3:0] watchdog_mode_cfg_i;
  logic [2:0] watchdog_prescale_sel_i;
  logic       int_enable_i;
  logic       clear_i;
  logic       wake_o;
  logic       timeout_irq_o;
  logic       timeout_flag_o;
  logic       dev_reset_o;
  int         n_mismatch;     // Count of failed comparisons.
  int         n_tests;        // Count of comparisons made.
  int         slow_cnt = 0;   // Phase counter of the slow oscillator.
  int         n_wake = 0;     // Wake pulses seen since the start of the run.
  int         n;              // Measured cycle count.

  wdtt_top #(.RST_DELAY_TICKS(DLY)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .slow_internal_osc_i(slow_internal_osc_i),
    .watchdog_mode_cfg_i(watchdog_mode_cfg_i),
    .watchdog_prescale_sel_i(watchdog_prescale_sel_i), .int_enable_i(int_enable_i),
    .clear_i(clear_i), .wake_o(wake_o), .timeout_irq_o(timeout_irq_o),
    .timeout_flag_o(timeout_flag_o), .dev_reset_o(dev_reset_o));

  // The clock runs at 100 MHz.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The slow oscillator toggles every HALF cycles, so the period is exact.
  always @(posedge clk_i) begin
    slow_cnt <= (slow_cnt == HALF - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == HALF - 1) begin
      slow_internal_osc_i <= ~slow_internal_osc_i;
    end
    if (wake_o === 1'b1) begin
      n_wake <= n_wake + 1;
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Resets for 6 cycles with the given mode field, which is captured on release.
  task automatic do_reset(input logic [3:0] mode);
    @(posedge clk_i);
    rst_i               <= 1'b1;
    watchdog_mode_cfg_i <= mode;
    repeat (6) @(posedge clk_i);
    rst_i               <= 1'b0;
    @(negedge clk_i);
    check({wake_o, timeout_irq_o, timeout_flag_o, dev_reset_o}, 32'h0);
  endtask

  // Counts falling edges until a wake pulse is seen, bounded by lim.
  task automatic wait_wake(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_i);
      cnt++;
    end while (wake_o !== 1'b1 && cnt < lim);
  endtask

  // Timer mode: interval is 64 divided slow periods; every expiry wakes and interrupts.
  task automatic t_periods();
    int div;
    for (int s = 0; s < 4; s++) begin
      div = (s == 0) ? 1 : (1 << (s + 1));
      @(posedge clk_i);
      watchdog_prescale_sel_i <= 3'(s);
      int_enable_i            <= 1'b1;
      wait_wake(9000, n);
      wait_wake(9000, n);
      check(n, 2 * HALF * INTERVAL_COUNT * div);
      check(timeout_irq_o, 1'b1);
      check(timeout_flag_o, 1'b1);
      check(dev_reset_o, 1'b0);
    end
  endtask

  // A masked interrupt stays quiet; a clear drops the flag.
  task automatic t_irq_mask();
    @(posedge clk_i);
    int_enable_i <= 1'b0;
    wait_wake(9000, n);
    check(wake_o, 1'b1);
    check(timeout_irq_o, 1'b0);
    @(posedge clk_i);
    clear_i <= 1'b1;
    @(posedge clk_i);
    clear_i <= 1'b0;
    @(negedge clk_i);
    check(timeout_flag_o, 1'b0);
  endtask

  // Reset mode: service holds off expiry and cancels a started delay; neglect gives a reset.
  task automatic t_service();
    int base;
    do_reset(4'h0);
    @(posedge clk_i);
    watchdog_prescale_sel_i <= 3'h0;
    base = n_wake;
    repeat (8) begin
      repeat (300) @(posedge clk_i);
      clear_i <= 1'b1;
      @(posedge clk_i);
      clear_i <= 1'b0;
    end
    @(negedge clk_i);
    check(n_wake, base);
    check(dev_reset_o, 1'b0);
    wait_wake(1000, n);
    check(wake_o, 1'b1);
    @(posedge clk_i);
    clear_i <= 1'b1;
    @(posedge clk_i);
    clear_i <= 1'b0;
    repeat (4 * DLY * 2 * HALF) @(negedge clk_i);
    check(dev_reset_o, 1'b0);
    wait_wake(1000, n);
    check(wake_o, 1'b1);
    check(dev_reset_o, 1'b0);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (dev_reset_o !== 1'b1 && n < 100);
    check(n, DLY * 2 * HALF);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Every input gets a value at time zero, then the scenarios run in turn.
  initial begin
    rst_i = 1'b1;
    watchdog_mode_cfg_i = MODE_TIMER;
    watchdog_prescale_sel_i = 3'h0;
    int_enable_i = 1'b0;
    clear_i = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    do_reset(MODE_TIMER);
    t_periods();
    t_irq_mask();
    t_service();
    stop_test();
  end

  // A hang is cut short well beyond the roughly 42000 cycles the tests need.
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end
endmodule
